/* bench/nv_access_ctrl_tb.sv */
// Purpose: self-checking bench for the non-volatile access controller
// Assumes: full-length program cycle of about 1024 clocks, no shortening
// Notes:   inputs change at the falling edge; xorshift stimulus, fixed seed
`timescale 1ns/1ps
module nv_access_ctrl_tb;
  logic       clk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic       sfr_wr_i = 1'b0;
  logic       sfr_rd_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic       bank_select_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic       nv_done_irq_enable_i = 1'b0;
  logic       global_irq_enable_i = 1'b0;
  logic       stack_full_i = 1'b0;
  logic       irq_service_i = 1'b0;
  logic [7:0] sfr_rdata_o;
  logic       nv_done_flag_o;
  logic       irq_call_o;
  logic       global_irq_clear_o;
  int         fail_count = 0;
  int         n_compared = 0;
  logic [31:0] seed = 32'h16d3;
  logic [7:0] pa [3];
  logic [7:0] pd [3];
  nv_access_ctrl nv_access_ctrl_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_addr_i(sfr_addr_i), .bank_select_i(bank_select_i),
    .sfr_wdata_i(sfr_wdata_i), .nv_done_irq_enable_i(nv_done_irq_enable_i),
    .global_irq_enable_i(global_irq_enable_i), .stack_full_i(stack_full_i),
    .irq_service_i(irq_service_i), .sfr_rdata_o(sfr_rdata_o), .nv_done_flag_o(nv_done_flag_o),
    .irq_call_o(irq_call_o), .global_irq_clear_o(global_irq_clear_o));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [7:0] exp_addr(input logic [7:0] v);
    return {3'h0, v[4:0]};
  endfunction : exp_addr
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask : chk1
  task automatic wr(input logic [7:0] a, input logic b, input logic [7:0] d);
    @(negedge clk_i);
    sfr_wr_i = 1'b1;
    sfr_addr_i = a;
    bank_select_i = b;
    sfr_wdata_i = d;
    @(negedge clk_i);
    sfr_wr_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic b, output logic [7:0] d);
    @(negedge clk_i);
    sfr_rd_i = 1'b1;
    sfr_addr_i = a;
    bank_select_i = b;
    @(negedge clk_i);
    sfr_rd_i = 1'b0;
    d = sfr_rdata_o;
  endtask : rd
  task automatic wait_idle(input int b);
    logic [7:0] c;
    int n;
    n = 0;
    rd(nv_access_pkg::CTRL_OFF, 1'b1, c);
    while (c[b] === 1'b1 && n < 1500) begin
      rd(nv_access_pkg::CTRL_OFF, 1'b1, c);
      n++;
    end
    chk1(c[b], 1'b0, "go bit not cleared by hardware");
  endtask : wait_idle
  initial begin
    #100000;
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end
  initial begin
    logic [7:0] v;
    int n;
    repeat (8) @(negedge clk_i);
    reset_n_i = 1'b1;
    rd(nv_access_pkg::ADDR_OFF, 1'b0, v);
    chk8(v, 8'h00, "address reset");
    rd(nv_access_pkg::DATA_OFF, 1'b0, v);
    chk8(v, 8'h00, "data reset");
    rd(nv_access_pkg::CTRL_OFF, 1'b1, v);
    chk8(v, 8'h00, "control reset");
    wr(nv_access_pkg::ADDR_OFF, 1'b0, 8'hff);
    rd(nv_access_pkg::ADDR_OFF, 1'b0, v);
    chk8(v, exp_addr(8'hff), "address width");
    wr(nv_access_pkg::CTRL_OFF, 1'b0, 8'h02);
    rd(nv_access_pkg::CTRL_OFF, 1'b1, v);
    chk8(v, 8'h00, "control written from bank 0");
    wr(nv_access_pkg::CTRL_OFF, 1'b1, 8'h0c);
    rd(nv_access_pkg::CTRL_OFF, 1'b1, v);
    chk8(v, 8'h08, "program go without prior enable");
    wr(nv_access_pkg::CTRL_OFF, 1'b1, 8'h03);
    rd(nv_access_pkg::CTRL_OFF, 1'b1, v);
    chk8(v, 8'h02, "fetch go without prior enable");
    rd(nv_access_pkg::CTRL_OFF, 1'b0, v);
    chk8(v, 8'h00, "control seen in bank 0");
    wr(nv_access_pkg::CTRL_OFF, 1'b1, 8'h00);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      pa[i] = (i == 0) ? 8'h1f : {3'h0, seed[4:2], 2'(i)};
      pd[i] = seed[15:8];
      stack_full_i = 1'b1;
      nv_done_irq_enable_i = (i != 1);
      global_irq_enable_i = 1'b0;
      wr(nv_access_pkg::ADDR_OFF, 1'b0, pa[i]);
      wr(nv_access_pkg::DATA_OFF, 1'b0, pd[i]);
      wr(nv_access_pkg::CTRL_OFF, 1'b1, 8'h08);
      wr(nv_access_pkg::CTRL_OFF, 1'b1, 8'h0c);
      global_irq_enable_i = (i != 2);
      wr(nv_access_pkg::ADDR_OFF, 1'b0, seed[23:16]);
      wr(nv_access_pkg::DATA_OFF, 1'b0, seed[31:24]);
      wr(nv_access_pkg::CTRL_OFF, 1'b1, 8'h0e);
      rd(nv_access_pkg::CTRL_OFF, 1'b1, v);
      chk8(v, 8'h0e, "program busy or restart accepted");
      wait_idle(nv_access_pkg::PGO_BIT);
      chk1(nv_done_flag_o, 1'b1, "done flag");
      chk1(irq_call_o, 1'b0, "call with full stack");
      stack_full_i = 1'b0;
      n = 0;
      repeat (4) begin
        @(negedge clk_i);
        if (irq_call_o === 1'b1) n++;
      end
      chk1(n != 0, i == 0, "vector call");
      irq_service_i = 1'b1;
      @(negedge clk_i);
      irq_service_i = 1'b0;
      n = (global_irq_clear_o === 1'b1);
      @(negedge clk_i);
      if (global_irq_clear_o === 1'b1) n++;
      chk1(n == 1, 1'b1, "global clear pulse");
      chk1(nv_done_flag_o, 1'b0, "flag cleared by service");
      wr(nv_access_pkg::CTRL_OFF, 1'b1, 8'h00);
    end
    for (int i = 0; i < 3; i++) begin
      wr(nv_access_pkg::DATA_OFF, 1'b0, ~pd[i]);
      wr(nv_access_pkg::ADDR_OFF, 1'b0, pa[i]);
      wr(nv_access_pkg::CTRL_OFF, 1'b1, 8'h01);
      rd(nv_access_pkg::DATA_OFF, 1'b0, v);
      chk8(v, ~pd[i], "read ran while disabled");
      wr(nv_access_pkg::CTRL_OFF, 1'b1, 8'h02);
      wr(nv_access_pkg::CTRL_OFF, 1'b1, 8'h03);
      wait_idle(nv_access_pkg::FGO_BIT);
      rd(nv_access_pkg::DATA_OFF, 1'b0, v);
      chk8(v, pd[i], "read back programmed byte");
      rd(nv_access_pkg::DATA_OFF, 1'b0, v);
      chk8(v, pd[i], "read result held");
      wr(nv_access_pkg::CTRL_OFF, 1'b1, 8'h00);
    end
    end_of_test();
  end
endmodule : nv_access_ctrl_tb

/* logic/nv_access_ctrl.sv */
// Purpose: byte read and program cycles on a 32x8 non-volatile array
// Assumes: cpu drives one special-register strobe per access, inputs synchronous
// Notes:   program cycle timed by a free-running tick, so its length varies
`timescale 1ns/1ps
module nv_access_ctrl (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       bank_select_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       nv_done_irq_enable_i,
  input  wire logic       global_irq_enable_i,
  input  wire logic       stack_full_i,
  input  wire logic       irq_service_i,
  output logic      [7:0] sfr_rdata_o,
  output logic            nv_done_flag_o,
  output logic            irq_call_o,
  output logic            global_irq_clear_o
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_PROG = 3'b100
  } cyc_state_e;

  cyc_state_e                               state_reg;
  logic [7:0]                               array_reg [nv_access_pkg::ARRAY_DEPTH];
  logic [nv_access_pkg::ADDR_W-1:0]         addr_reg;
  logic [7:0]                               data_reg;
  logic [nv_access_pkg::ADDR_W-1:0]         lat_addr_reg;
  logic [7:0]                               lat_data_reg;
  logic [3:0]                               ctrl_reg;
  logic [7:0]                               tick_cnt_reg;
  logic                                     tick;
  logic [7:0]                               cyc_cnt_reg;
  logic                                     wr_addr;
  logic                                     wr_data;
  logic                                     wr_ctrl;
  logic                                     rd_ctrl;
  logic                                     start_read;
  logic                                     start_prog;
  logic                                     read_done;
  logic                                     prog_done;
  logic [10:0]                              prog_cyc_reg;

  assign wr_addr = sfr_wr_i && sfr_addr_i == nv_access_pkg::ADDR_OFF;
  assign wr_data = sfr_wr_i && sfr_addr_i == nv_access_pkg::DATA_OFF;
  assign wr_ctrl = sfr_wr_i && sfr_addr_i == nv_access_pkg::CTRL_OFF
                   && bank_select_i == nv_access_pkg::CTRL_BANK;
  assign rd_ctrl = sfr_addr_i == nv_access_pkg::CTRL_OFF
                   && bank_select_i == nv_access_pkg::CTRL_BANK;

  // go bits only start from idle with the enable already stored
  assign start_prog = wr_ctrl && state_reg == ST_IDLE
                      && sfr_wdata_i[nv_access_pkg::PGO_BIT]
                      && ctrl_reg[nv_access_pkg::PEN_BIT];
  assign start_read = wr_ctrl && state_reg == ST_IDLE && !start_prog
                      && sfr_wdata_i[nv_access_pkg::FGO_BIT]
                      && ctrl_reg[nv_access_pkg::FEN_BIT];
  assign read_done  = state_reg == ST_READ
                      && cyc_cnt_reg == 8'(nv_access_pkg::READ_CYCLES - 1);
  assign prog_done  = state_reg == ST_PROG && tick
                      && cyc_cnt_reg == 8'(nv_access_pkg::PROG_TICKS - 1);

  // free-running programming timer, unrelated to cycle start
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_cnt_reg <= 8'h00;
    end else if (tick) begin
      tick_cnt_reg <= 8'h00;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 8'h01;
    end
  end
  assign tick = tick_cnt_reg == 8'(nv_access_pkg::TICK_CYCLES - 1);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg   <= ST_IDLE;
      cyc_cnt_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          cyc_cnt_reg <= 8'h00;
          if (start_prog) begin
            state_reg <= ST_PROG;
          end else if (start_read) begin
            state_reg <= ST_READ;
          end
        end
        ST_READ: begin
          if (read_done) begin
            state_reg <= ST_IDLE;
          end else begin
            cyc_cnt_reg <= cyc_cnt_reg + 8'h01;
          end
        end
        ST_PROG: begin
          if (prog_done) begin
            state_reg <= ST_IDLE;
          end else if (tick) begin
            cyc_cnt_reg <= cyc_cnt_reg + 8'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_reg <= nv_access_pkg::CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg[nv_access_pkg::PEN_BIT] <= sfr_wdata_i[nv_access_pkg::PEN_BIT];
        ctrl_reg[nv_access_pkg::FEN_BIT] <= sfr_wdata_i[nv_access_pkg::FEN_BIT];
      end
      if (start_prog) begin
        ctrl_reg[nv_access_pkg::PGO_BIT] <= 1'b1;
      end else if (prog_done) begin
        ctrl_reg[nv_access_pkg::PGO_BIT] <= 1'b0;
      end
      if (start_read) begin
        ctrl_reg[nv_access_pkg::FGO_BIT] <= 1'b1;
      end else if (read_done) begin
        ctrl_reg[nv_access_pkg::FGO_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_reg     <= nv_access_pkg::ADDR_RST;
      lat_addr_reg <= nv_access_pkg::ADDR_RST;
      lat_data_reg <= nv_access_pkg::DATA_RST;
    end else begin
      if (wr_addr) begin
        addr_reg <= sfr_wdata_i[nv_access_pkg::ADDR_W-1:0];
      end
      if (start_prog || start_read) begin
        lat_addr_reg <= addr_reg;
        lat_data_reg <= data_reg;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_reg <= nv_access_pkg::DATA_RST;
    end else if (read_done) begin
      data_reg <= array_reg[lat_addr_reg];
    end else if (wr_data) begin
      data_reg <= sfr_wdata_i;
    end
  end

  // array contents are non-volatile, so no reset
  always_ff @(posedge clk_i) begin
    if (prog_done) begin
      array_reg[lat_addr_reg] <= lat_data_reg;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      if (sfr_addr_i == nv_access_pkg::ADDR_OFF) begin
        sfr_rdata_o <= {3'h0, addr_reg};
      end else if (sfr_addr_i == nv_access_pkg::DATA_OFF) begin
        sfr_rdata_o <= data_reg;
      end else if (rd_ctrl) begin
        sfr_rdata_o <= {4'h0, ctrl_reg};
      end else begin
        sfr_rdata_o <= 8'h00;
      end
    end
  end

  // done flag: set wins over service clear
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nv_done_flag_o     <= 1'b0;
      irq_call_o         <= 1'b0;
      global_irq_clear_o <= 1'b0;
    end else begin
      if (prog_done) begin
        nv_done_flag_o <= 1'b1;
      end else if (irq_service_i) begin
        nv_done_flag_o <= 1'b0;
      end
      irq_call_o <= nv_done_flag_o && nv_done_irq_enable_i && global_irq_enable_i
                    && !stack_full_i && !irq_service_i && !irq_call_o;
      global_irq_clear_o <= irq_service_i;
    end
  end

  // cycles spent in the current programming cycle, for the length check
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prog_cyc_reg <= 11'h000;
    end else if (state_reg != ST_PROG) begin
      prog_cyc_reg <= 11'h000;
    end else begin
      prog_cyc_reg <= prog_cyc_reg + 11'h001;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_prog_start;
    state_reg == ST_IDLE && start_prog;
  endsequence
  sequence s_prog_busy;
    ctrl_reg[nv_access_pkg::PGO_BIT] [*8];
  endsequence

  a_prog_needs_en: assert property (wr_ctrl && !ctrl_reg[nv_access_pkg::PEN_BIT]
    && state_reg == ST_IDLE |=> !ctrl_reg[nv_access_pkg::PGO_BIT])
    else $error("program began without enable");
  a_read_needs_en: assert property (wr_ctrl && !ctrl_reg[nv_access_pkg::FEN_BIT]
    && state_reg == ST_IDLE |=> !ctrl_reg[nv_access_pkg::FGO_BIT])
    else $error("read began without enable");
  a_prog_go_held: assert property (s_prog_start |=> s_prog_busy)
    else $error("program go dropped early");
  a_read_clears: assert property (start_read |=> ctrl_reg[nv_access_pkg::FGO_BIT] [*2]
    ##1 !ctrl_reg[nv_access_pkg::FGO_BIT]) else $error("read go not cleared in time");
  a_read_data: assert property (read_done |=> data_reg == $past(array_reg[lat_addr_reg]))
    else $error("read result not loaded");
  a_done_flag: assert property ($fell(ctrl_reg[nv_access_pkg::PGO_BIT]) |-> nv_done_flag_o)
    else $error("program end did not set flag");
  a_call_gate: assert property (irq_call_o |-> $past(nv_done_flag_o && global_irq_enable_i
    && nv_done_irq_enable_i && !stack_full_i)) else $error("call without its conditions");
  a_service_clr: assert property (irq_service_i && !prog_done |=> !nv_done_flag_o
    && global_irq_clear_o) else $error("service did not clear flag");
  a_addr_upper: assert property (sfr_rd_i && sfr_addr_i == nv_access_pkg::ADDR_OFF
    |=> sfr_rdata_o[7:5] == 3'h0) else $error("address upper bits not zero");
  a_latch_hold: assert property (state_reg != ST_IDLE && $past(state_reg) != ST_IDLE
    |-> $stable(lat_addr_reg) && $stable(lat_data_reg)) else $error("latched operands moved");
  a_prog_length: assert property (prog_done
    |-> int'(prog_cyc_reg) >= (nv_access_pkg::PROG_TICKS - 1) * nv_access_pkg::TICK_CYCLES
    && int'(prog_cyc_reg) < nv_access_pkg::PROG_TICKS * nv_access_pkg::TICK_CYCLES)
    else $error("program cycle length out of range");
endmodule : nv_access_ctrl

/* pkg/nv_access_pkg.sv */
// Purpose: constants for the byte-wide non-volatile access controller
// Assumes: 250 MHz system clock, cpu special-register write/read strobes
// Notes:   address and data offsets sit in the special-register area
package nv_access_pkg;
  localparam int          CLK_PERIOD_NS   = 4;
  localparam int          ARRAY_DEPTH     = 32;
  localparam int          ADDR_W          = 5;
  localparam logic [7:0]  ADDR_OFF        = 8'h1a;
  localparam logic [7:0]  DATA_OFF        = 8'h1b;
  localparam logic [7:0]  CTRL_OFF        = 8'h40;
  localparam logic        CTRL_BANK       = 1'b1;
  localparam int          PEN_BIT         = 3;
  localparam int          PGO_BIT         = 2;
  localparam int          FEN_BIT         = 1;
  localparam int          FGO_BIT         = 0;
  localparam logic [4:0]  ADDR_RST        = 5'h00;
  localparam logic [7:0]  DATA_RST        = 8'h00;
  localparam logic [3:0]  CTRL_RST        = 4'h0;
  localparam int          READ_TIME_NS    = 8;
  localparam int          READ_CYCLES     = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          TICK_TIME_NS    = 128;
  localparam int          TICK_CYCLES     = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int          PROG_TIME_NS    = 4096;
  localparam int          PROG_TICKS      = PROG_TIME_NS / TICK_TIME_NS;
endpackage : nv_access_pkg
